/* File: logic/acc_pkg.sv */
// Purpose: constants, types and register map of one axis counter/compare block
// Assumes: APB slave, 32-bit data, 8-bit byte address, one clock pclk
// Notes:   Function list below; the logic is in acc_axis_regs.sv
//
// Function
// - vibration reduction on only if both times nonzero
// - rise time is bits 0-15, 32-tick unit
// - fall time is bits 16-31, 32-tick unit
// - command counter counts command pulses, 28-bit signed
// - mechanical counter source: command, encoder or pulsar
// - deflection counter counts difference of two sources
// - general counter: command, encoder, pulsar or clock/2
// - sign-extension bits ignore writes, read as sign
// - unused bits ignore writes and read zero
// - comparators 1-4 each hold signed compare data
// - comparator 5 data queued in a second stage
// - event raises interrupt only when enabled
// - enable bits 0-3: stop, next, prereg, queue
// - enable bits 4-7: accel and decel edges
// - enable bits 8-12: comparators 1 to 5 met
// - enable bits 13-15: clear, latch, origin latch
// - enable bits 16-18: slowdown, direction change, start
// - latch register captures command counter on trigger
// - two-bit select picks the latch trigger

`default_nettype none

package acc_pkg;

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFF_VIB     = 8'h00;
  localparam logic [7:0]  OFF_CNT_CMD = 8'h04;
  localparam logic [7:0]  OFF_CNT_MEC = 8'h08;
  localparam logic [7:0]  OFF_CNT_DEF = 8'h0c;
  localparam logic [7:0]  OFF_CNT_GEN = 8'h10;
  localparam logic [7:0]  OFF_CMP1    = 8'h14;
  localparam logic [7:0]  OFF_CMP5    = 8'h24;
  localparam logic [7:0]  OFF_IRQ_EN  = 8'h28;
  localparam logic [7:0]  OFF_LATCH   = 8'h2c;
  localparam logic [7:0]  OFF_CTRL    = 8'h30;

  // ********************************************************************
  // fields, widths and reset values
  // ********************************************************************
  localparam int unsigned POS_W        = 28;
  localparam int unsigned DEF_W        = 16;
  localparam int unsigned VIB_W        = 16;
  localparam int unsigned VIB_RT_LSB   = 0;
  localparam int unsigned VIB_FT_LSB   = 16;
  localparam int unsigned IRQ_W        = 19;
  localparam int unsigned NUM_CMP      = 5;
  localparam int unsigned CTRL_MEC_LSB = 0;
  localparam int unsigned CTRL_DEF_LSB = 2;
  localparam int unsigned CTRL_GEN_LSB = 4;
  localparam int unsigned CTRL_LTS_LSB = 6;
  localparam int unsigned CTRL_LTCMD   = 8;
  localparam logic [31:0] RST_VIB      = 32'h0000_0000;
  localparam logic [18:0] RST_IRQ_EN   = 19'h0_0000;
  localparam logic [27:0] RST_POS      = 28'h000_0000;
  localparam logic [15:0] RST_DEF      = 16'h0000;
  localparam logic [4:0]  VIB_UNIT_MAX = 5'h1f;  // 32 reference ticks per unit

  // event bit positions in the enable register
  localparam int unsigned EV_STOP   = 0;
  localparam int unsigned EV_NEXT   = 1;
  localparam int unsigned EV_PREREG = 2;
  localparam int unsigned EV_QUEUE5 = 3;
  localparam int unsigned EV_ACC_B  = 4;
  localparam int unsigned EV_ACC_F  = 5;
  localparam int unsigned EV_DEC_B  = 6;
  localparam int unsigned EV_DEC_F  = 7;
  localparam int unsigned EV_CMP1   = 8;
  localparam int unsigned EV_CLEAR  = 13;
  localparam int unsigned EV_LATCH  = 14;
  localparam int unsigned EV_ORIGIN = 15;
  localparam int unsigned EV_SLOW   = 16;
  localparam int unsigned EV_DIR    = 17;
  localparam int unsigned EV_START  = 18;

  // ********************************************************************
  // types
  // ********************************************************************
  typedef enum logic [1:0] {
    ACC_SRC_CMD  = 2'h0,
    ACC_SRC_ENC  = 2'h1,
    ACC_SRC_PUL  = 2'h2,
    ACC_SRC_HALF = 2'h3
  } acc_src_t;

  typedef enum logic [1:0] {
    ACC_LT_LATCH  = 2'h0,
    ACC_LT_ORIGIN = 2'h1,
    ACC_LT_CMP4   = 2'h2,
    ACC_LT_CMP5   = 2'h3
  } acc_lt_sel_t;

  typedef enum logic [1:0] {
    ACC_VIB_IDLE = 2'h0,
    ACC_VIB_RISE = 2'h1,
    ACC_VIB_FALL = 2'h3
  } acc_vib_state_t;

  typedef struct packed {
    logic encoder_a;
    logic encoder_b;
    logic pulsar_a;
    logic pulsar_b;
    logic latch_input;
    logic origin_input;
    logic count_clear_input;
    logic slowdown_input;
    logic dir_plus;
    logic dir_minus;
    logic shared_start_input;
  } acc_pins_t;

  typedef struct packed {
    logic normal_stop;
    logic next_start;
    logic prereg_write;
    logic accel_begin;
    logic accel_finish;
    logic decel_begin;
    logic decel_finish;
  } acc_motion_t;

endpackage

`default_nettype wire

/* File: logic/acc_axis_regs.sv */
// Purpose: axis counters, comparators, latch, event enables, vibration timing
// Assumes: APB slave on pclk; pins are asynchronous, motion strobes are on pclk
// Notes:   APB answers in the second access cycle; outputs are all registered

`default_nettype none

module acc_axis_regs (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  // pulse generator side
  input  wire logic                       cmd_pulse,
  input  wire logic                       cmd_dir_neg,
  input  wire acc_pkg::acc_motion_t       motion_events,
  // external pins
  input  wire acc_pkg::acc_pins_t         pins_async,
  // outputs
  output logic                            event_irq,
  output logic [18:0]                     event_cause,
  output logic                            vib_enabled,
  output acc_pkg::acc_vib_state_t         vib_window,
  output logic [4:0]                      cmp_met_out
);

  // ********************************************************************
  // helpers
  // ********************************************************************
  // 4x quadrature decode; 2'b01 is +1, 2'b11 is -1
  function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
    logic [3:0] tr;
    tr = {prev, cur};
    unique case (tr)
      4'h1, 4'h7, 4'he, 4'h8: quad_step = 2'b01;
      4'h2, 4'hb, 4'hd, 4'h4: quad_step = 2'b11;
      default:                quad_step = 2'b00;
    endcase
  endfunction

  function automatic logic [27:0] ext_pos(input logic [1:0] s);
    ext_pos = {{26{s[1]}}, s};
  endfunction

  function automatic logic [15:0] ext_def(input logic [1:0] s);
    ext_def = {{14{s[1]}}, s};
  endfunction

  function automatic logic [31:0] sext_pos(input logic [27:0] v);
    sext_pos = {{4{v[27]}}, v};
  endfunction

  // ********************************************************************
  // apb handshake
  // ********************************************************************
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        acc_first;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_mux;

  assign acc_first = psel & penable & ~pready_q;
  assign wr_en     = psel & penable & pready_q & pwrite;
  assign mapped    = (paddr[1:0] == 2'h0) && (paddr <= acc_pkg::OFF_CTRL);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= acc_first;
      pslverr_q <= acc_first & ~mapped;
      if (acc_first)
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // ********************************************************************
  // pin synchronisers and edges
  // ********************************************************************
  acc_pkg::acc_pins_t sync1_q;
  acc_pkg::acc_pins_t sync2_q;
  acc_pkg::acc_pins_t sync3_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end
    else
    begin
      sync1_q <= pins_async;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic       ltc_rise;
  logic       org_rise;
  logic       clr_rise;
  logic       sd_rise;
  logic       dir_chg;
  logic       sta_rise;
  logic [1:0] cmd_step;
  logic [1:0] enc_step;
  logic [1:0] pul_step;

  assign ltc_rise = sync2_q.latch_input & ~sync3_q.latch_input;
  assign org_rise = sync2_q.origin_input & ~sync3_q.origin_input;
  assign clr_rise = sync2_q.count_clear_input & ~sync3_q.count_clear_input;
  assign sd_rise  = sync2_q.slowdown_input & ~sync3_q.slowdown_input;
  assign sta_rise = sync2_q.shared_start_input & ~sync3_q.shared_start_input;
  assign dir_chg  = (sync2_q.dir_plus ^ sync3_q.dir_plus) | (sync2_q.dir_minus ^ sync3_q.dir_minus);
  assign cmd_step = cmd_pulse ? (cmd_dir_neg ? 2'b11 : 2'b01) : 2'b00;
  assign enc_step = quad_step({sync3_q.encoder_a, sync3_q.encoder_b}, {sync2_q.encoder_a, sync2_q.encoder_b});
  assign pul_step = quad_step({sync3_q.pulsar_a, sync3_q.pulsar_b}, {sync2_q.pulsar_a, sync2_q.pulsar_b});

  // ********************************************************************
  // control and configuration registers
  // ********************************************************************
  logic [31:0] vib_q;
  logic [18:0] irq_en_q;
  acc_pkg::acc_src_t    mec_src_q;
  acc_pkg::acc_src_t    def_src_q;
  acc_pkg::acc_src_t    gen_src_q;
  acc_pkg::acc_lt_sel_t lt_sel_q;
  logic        latch_cmd;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vib_q     <= acc_pkg::RST_VIB;
      irq_en_q  <= acc_pkg::RST_IRQ_EN;
      mec_src_q <= acc_pkg::ACC_SRC_CMD;
      def_src_q <= acc_pkg::ACC_SRC_CMD;
      gen_src_q <= acc_pkg::ACC_SRC_CMD;
      lt_sel_q  <= acc_pkg::ACC_LT_LATCH;
    end
    else if (wr_en)
    begin
      if (paddr == acc_pkg::OFF_VIB)
        vib_q <= pwdata;
      if (paddr == acc_pkg::OFF_IRQ_EN)
        irq_en_q <= pwdata[18:0];
      if (paddr == acc_pkg::OFF_CTRL)
      begin
        mec_src_q <= acc_pkg::acc_src_t'(pwdata[acc_pkg::CTRL_MEC_LSB +: 2]);
        def_src_q <= acc_pkg::acc_src_t'(pwdata[acc_pkg::CTRL_DEF_LSB +: 2]);
        gen_src_q <= acc_pkg::acc_src_t'(pwdata[acc_pkg::CTRL_GEN_LSB +: 2]);
        lt_sel_q  <= acc_pkg::acc_lt_sel_t'(pwdata[acc_pkg::CTRL_LTS_LSB +: 2]);
      end
    end
  end

  assign latch_cmd = wr_en && (paddr == acc_pkg::OFF_CTRL) && pwdata[acc_pkg::CTRL_LTCMD];

  // ********************************************************************
  // counters
  // ********************************************************************
  logic [27:0] cnt_cmd_q;
  logic [27:0] cnt_mec_q;
  logic [15:0] cnt_def_q;
  logic [27:0] cnt_gen_q;
  logic        half_q;
  logic [1:0]  mec_step;
  logic [1:0]  gen_step;
  logic [15:0] def_delta;

  always_comb
  begin
    unique case (mec_src_q)
      acc_pkg::ACC_SRC_ENC: mec_step = enc_step;
      acc_pkg::ACC_SRC_PUL: mec_step = pul_step;
      default:              mec_step = cmd_step;
    endcase
    unique case (gen_src_q)
      acc_pkg::ACC_SRC_ENC:  gen_step = enc_step;
      acc_pkg::ACC_SRC_PUL:  gen_step = pul_step;
      acc_pkg::ACC_SRC_HALF: gen_step = {1'b0, half_q};
      default:               gen_step = cmd_step;
    endcase
    unique case (def_src_q)
      acc_pkg::ACC_SRC_ENC: def_delta = ext_def(cmd_step) - ext_def(pul_step);
      acc_pkg::ACC_SRC_PUL: def_delta = ext_def(enc_step) - ext_def(pul_step);
      default:              def_delta = ext_def(cmd_step) - ext_def(enc_step);
    endcase
  end

  // a register write beats a clear input, which beats counting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_cmd_q <= acc_pkg::RST_POS;
      cnt_mec_q <= acc_pkg::RST_POS;
      cnt_def_q <= acc_pkg::RST_DEF;
      cnt_gen_q <= acc_pkg::RST_POS;
      half_q    <= 1'b0;
    end
    else
    begin
      half_q <= ~half_q;
      if (wr_en && paddr == acc_pkg::OFF_CNT_CMD)
        cnt_cmd_q <= pwdata[27:0];
      else if (clr_rise)
        cnt_cmd_q <= acc_pkg::RST_POS;
      else
        cnt_cmd_q <= cnt_cmd_q + ext_pos(cmd_step);
      if (wr_en && paddr == acc_pkg::OFF_CNT_MEC)
        cnt_mec_q <= pwdata[27:0];
      else if (clr_rise)
        cnt_mec_q <= acc_pkg::RST_POS;
      else
        cnt_mec_q <= cnt_mec_q + ext_pos(mec_step);
      if (wr_en && paddr == acc_pkg::OFF_CNT_DEF)
        cnt_def_q <= pwdata[15:0];
      else if (clr_rise)
        cnt_def_q <= acc_pkg::RST_DEF;
      else
        cnt_def_q <= cnt_def_q + def_delta;
      if (wr_en && paddr == acc_pkg::OFF_CNT_GEN)
        cnt_gen_q <= pwdata[27:0];
      else if (clr_rise)
        cnt_gen_q <= acc_pkg::RST_POS;
      else
        cnt_gen_q <= cnt_gen_q + ext_pos(gen_step);
    end
  end

  // ********************************************************************
  // comparators
  // ********************************************************************
  logic [27:0] cmp_q [acc_pkg::NUM_CMP];
  logic [27:0] queue5_q;
  logic        queue5_full_q;
  logic        armed5_q;
  logic [4:0]  eq_now;
  logic [4:0]  eq_q;
  logic [4:0]  cmp_met;
  logic        queue5_wr;

  assign queue5_wr = wr_en && (paddr == acc_pkg::OFF_CMP5);

  always_comb
  begin
    for (int i = 0; i < acc_pkg::NUM_CMP; i++)
      eq_now[i] = (cnt_cmd_q == cmp_q[i]);
    cmp_met = eq_now & ~eq_q & {armed5_q, 4'hf};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < acc_pkg::NUM_CMP; i++)
        cmp_q[i] <= acc_pkg::RST_POS;
      eq_q          <= 5'h00;
      queue5_q      <= acc_pkg::RST_POS;
      queue5_full_q <= 1'b0;
      armed5_q      <= 1'b0;
    end
    else
    begin
      eq_q <= eq_now;
      for (int i = 0; i < acc_pkg::NUM_CMP - 1; i++)
        if (wr_en && paddr == acc_pkg::OFF_CMP1 + 8'(4 * i))
          cmp_q[i] <= pwdata[27:0];
      // queued value moves up once the active one is consumed
      if (queue5_wr)
      begin
        queue5_q      <= pwdata[27:0];
        queue5_full_q <= 1'b1;
      end
      else if (queue5_full_q && (!armed5_q || cmp_met[4]))
        queue5_full_q <= 1'b0;
      if (!queue5_wr && queue5_full_q && (!armed5_q || cmp_met[4]))
      begin
        cmp_q[4] <= queue5_q;
        armed5_q <= 1'b1;
      end
      else if (cmp_met[4])
        armed5_q <= 1'b0;
    end
  end

  // ********************************************************************
  // latch of the command position counter
  // ********************************************************************
  logic [27:0] latch_q;
  logic        lt_trig;

  always_comb
  begin
    unique case (lt_sel_q)
      acc_pkg::ACC_LT_ORIGIN: lt_trig = org_rise;
      acc_pkg::ACC_LT_CMP4:   lt_trig = cmp_met[3];
      acc_pkg::ACC_LT_CMP5:   lt_trig = cmp_met[4];
      default:                lt_trig = ltc_rise;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      latch_q <= acc_pkg::RST_POS;
    else if (lt_trig || latch_cmd)
      latch_q <= cnt_cmd_q;
  end

  // ********************************************************************
  // events
  // ********************************************************************
  logic [18:0] ev;
  logic        irq_q;
  logic [18:0] cause_q;

  always_comb
  begin
    ev                   = 19'h0_0000;
    ev[acc_pkg::EV_STOP]   = motion_events.normal_stop;
    ev[acc_pkg::EV_NEXT]   = motion_events.next_start;
    ev[acc_pkg::EV_PREREG] = motion_events.prereg_write;
    ev[acc_pkg::EV_QUEUE5] = queue5_wr;
    ev[acc_pkg::EV_ACC_B]  = motion_events.accel_begin;
    ev[acc_pkg::EV_ACC_F]  = motion_events.accel_finish;
    ev[acc_pkg::EV_DEC_B]  = motion_events.decel_begin;
    ev[acc_pkg::EV_DEC_F]  = motion_events.decel_finish;
    ev[acc_pkg::EV_CMP1 +: 5] = cmp_met;
    ev[acc_pkg::EV_CLEAR]  = clr_rise;
    ev[acc_pkg::EV_LATCH]  = ltc_rise && lt_sel_q == acc_pkg::ACC_LT_LATCH;
    ev[acc_pkg::EV_ORIGIN] = org_rise && lt_sel_q == acc_pkg::ACC_LT_ORIGIN;
    ev[acc_pkg::EV_SLOW]   = sd_rise;
    ev[acc_pkg::EV_DIR]    = dir_chg;
    ev[acc_pkg::EV_START]  = sta_rise;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_q   <= 1'b0;
      cause_q <= 19'h0_0000;
    end
    else
    begin
      cause_q <= ev & irq_en_q;
      irq_q   <= |(ev & irq_en_q);
    end
  end

  assign event_irq   = irq_q;
  assign event_cause = cause_q;

  // ********************************************************************
  // vibration reduction windows
  // ********************************************************************
  logic [15:0] rise_window_time;
  logic [15:0] fall_window_time;
  logic        vib_on;
  logic        vib_on_q;
  logic [4:0]  presc_q;
  logic [15:0] units_q;
  logic        unit_tick;
  acc_pkg::acc_vib_state_t vib_st_q;

  assign rise_window_time = vib_q[acc_pkg::VIB_RT_LSB +: acc_pkg::VIB_W];
  assign fall_window_time = vib_q[acc_pkg::VIB_FT_LSB +: acc_pkg::VIB_W];
  assign vib_on           = (rise_window_time != 16'h0000) && (fall_window_time != 16'h0000);
  assign unit_tick        = (presc_q == acc_pkg::VIB_UNIT_MAX);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vib_st_q <= acc_pkg::ACC_VIB_IDLE;
      presc_q  <= 5'h00;
      units_q  <= 16'h0000;
      vib_on_q <= 1'b0;
    end
    else
    begin
      vib_on_q <= vib_on;
      presc_q  <= presc_q + 5'h01;
      if (!vib_on)
        vib_st_q <= acc_pkg::ACC_VIB_IDLE;
      else
      begin
        unique case (vib_st_q)
          acc_pkg::ACC_VIB_IDLE:
            if (cmd_pulse)
            begin
              vib_st_q <= acc_pkg::ACC_VIB_RISE;
              units_q  <= rise_window_time;
              presc_q  <= 5'h00;
            end
          acc_pkg::ACC_VIB_RISE:
            if (unit_tick)
            begin
              if (units_q == 16'h0001)
              begin
                vib_st_q <= acc_pkg::ACC_VIB_FALL;
                units_q  <= fall_window_time;
              end
              else
                units_q <= units_q - 16'h0001;
            end
          acc_pkg::ACC_VIB_FALL:
            if (unit_tick)
            begin
              if (units_q == 16'h0001)
                vib_st_q <= acc_pkg::ACC_VIB_IDLE;
              else
                units_q <= units_q - 16'h0001;
            end
          default:
            vib_st_q <= acc_pkg::ACC_VIB_IDLE;
        endcase
      end
    end
  end

  assign vib_enabled = vib_on_q;
  assign vib_window  = vib_st_q;

  logic [4:0] met_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      met_q <= 5'h00;
    else
      met_q <= cmp_met;
  end

  assign cmp_met_out = met_q;

  // ********************************************************************
  // read mux
  // ********************************************************************
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      acc_pkg::OFF_VIB:     rd_mux = vib_q;
      acc_pkg::OFF_CNT_CMD: rd_mux = sext_pos(cnt_cmd_q);
      acc_pkg::OFF_CNT_MEC: rd_mux = sext_pos(cnt_mec_q);
      acc_pkg::OFF_CNT_DEF: rd_mux = {{16{cnt_def_q[15]}}, cnt_def_q};
      acc_pkg::OFF_CNT_GEN: rd_mux = sext_pos(cnt_gen_q);
      8'h14:                rd_mux = sext_pos(cmp_q[0]);
      8'h18:                rd_mux = sext_pos(cmp_q[1]);
      8'h1c:                rd_mux = sext_pos(cmp_q[2]);
      8'h20:                rd_mux = sext_pos(cmp_q[3]);
      acc_pkg::OFF_CMP5:    rd_mux = sext_pos(cmp_q[4]);
      acc_pkg::OFF_IRQ_EN:  rd_mux = {13'h0000, irq_en_q};
      acc_pkg::OFF_LATCH:   rd_mux = sext_pos(latch_q);
      acc_pkg::OFF_CTRL:    rd_mux = {23'h00_0000, 1'b0, lt_sel_q, gen_src_q, def_src_q, mec_src_q};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

endmodule

`default_nettype wire

/* File: testbench/acc_quad_src.sv */
// Purpose: quadrature source for the encoder pins
// Assumes: phase steps every fourth pclk while run
// Notes:   b leads a, an up count for the decoder
`default_nettype none
module acc_quad_src (
  // control
  input  wire logic       pclk,
  input  wire logic       run,
  // {a, b}
  output logic      [1:0] ab
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_q;
  initial
  begin
    div_q = 0;
    ab = 0;
  end
  always @(posedge pclk)
  begin
    div_q <= div_q + 1;
    if (run && div_q == 0)
      ab <= {ab[0], ~ab[1]};
  end
endmodule
`default_nettype wire

/* File: testbench/acc_axis_regs_chk.sv */
// Purpose: port assertions of the axis block
// Assumes: one clock, async low reset
// Notes:   bound below
`default_nettype none
module acc_axis_regs_chk (
  // watched ports
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic [7:0]              paddr,
  input  wire logic                    pready,
  input  wire logic                    pslverr,
  input  wire logic                    cmd_pulse,
  input  wire acc_pkg::acc_motion_t    motion_events,
  input  wire logic                    event_irq,
  input  wire logic [18:0]             event_cause,
  input  wire acc_pkg::acc_vib_state_t vib_window,
  input  wire logic [4:0]              cmp_met_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy_once;
    pready |=> !pready;
  endproperty
  a_rdy_once: assert property (p_rdy_once) else $error("ready too long");
  property p_rdy_wait;
    psel && $rose(penable) |=> pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready late");
  property p_err_bad;
    pready && (paddr > 8'h30 || paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  a_err_bad: assert property (p_err_bad) else $error("no error flag");
  property p_irq_any;
    event_irq == (|event_cause);
  endproperty
  a_irq_any: assert property (p_irq_any) else $error("irq without cause");
  property p_ev_stop;
    event_cause[0] |-> $past(motion_events.normal_stop);
  endproperty
  a_ev_stop: assert property (p_ev_stop) else $error("stop cause wrong");
  property p_ev_acc;
    event_cause[4] |-> $past(motion_events.accel_begin);
  endproperty
  a_ev_acc: assert property (p_ev_acc) else $error("accel cause wrong");
  property p_vib_start;
    vib_window != acc_pkg::ACC_VIB_IDLE && $past(vib_window) == acc_pkg::ACC_VIB_IDLE |-> $past(cmd_pulse);
  endproperty
  a_vib_start: assert property (p_vib_start) else $error("window w/o pulse");
  property p_cmp_pulse;
    (cmp_met_out & $past(cmp_met_out)) == 5'h00;
  endproperty
  a_cmp_pulse: assert property (p_cmp_pulse) else $error("met too long");
  c_err: cover property (pready && pslverr);
  c_cmp: cover property (cmp_met_out[0]);
  c_irq: cover property (event_irq);
endmodule
bind acc_axis_regs acc_axis_regs_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .cmd_pulse(cmd_pulse), .motion_events(motion_events),
  .event_irq(event_irq), .event_cause(event_cause), .vib_window(vib_window), .cmp_met_out(cmp_met_out));
`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: self-checking bench of the axis block
// Assumes: apb answer one wait state
// Notes:   expected counts kept as ints
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cmd_pulse, cmd_dir_neg, event_irq, vib_enabled;
  logic er, b, enc_run;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, x, seed;
  logic [18:0] event_cause;
  logic [4:0] cmp_met_out;
  logic [1:0] enc, e_q;
  logic [6:0] pin_lvl;
  acc_pkg::acc_vib_state_t vib_window;
  acc_pkg::acc_motion_t mev;
  int fails, total_checks, cyc, cnt, ecnt, p;
  acc_axis_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .cmd_pulse(cmd_pulse),
    .cmd_dir_neg(cmd_dir_neg), .motion_events(mev), .pins_async({enc, 2'h0, pin_lvl}), .event_irq(event_irq),
    .event_cause(event_cause), .vib_enabled(vib_enabled), .vib_window(vib_window), .cmp_met_out(cmp_met_out));
  acc_quad_src i_enc (.pclk(pclk), .run(enc_run), .ab(enc));
  initial
  begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] sx(input logic [31:0] v, input int w);
    return 32'($signed(v << (32 - w)) >>> (32 - w));
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic final_report;
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    e_q <= enc;
    if (e_q != enc)
      ecnt++;
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      final_report();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cmd_pulse, cmd_dir_neg, mev, pin_lvl, enc_run} = '0;
    seed = 32'h45;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int a = 0; a < 11; a++)
    begin
      x = rnd();
      bus(1, 8'(a * 4), a == 10 ? {13'h0, x[18:0]} : x);
      bus(0, 8'(a * 4), 0);
      chk("reg", rd, a == 0 ? x : a == 3 ? sx(x, 16) : a == 10 ? {13'h0, x[18:0]} : sx(x, 28));
    end
    bus(0, 8'h34, 0);
    chk("err", 32'(er), 1);
    chk("unmapped", rd, 0);
    for (int i = 0; i < 3; i++)
    begin
      bus(1, 8'h00, i == 0 ? 32'h10000 : i == 1 ? 32'h1 : 32'h10001);
      @(posedge pclk);
      chk("vib", 32'(vib_enabled), 32'(i == 2));
    end
    bus(1, 8'h14, 32'hffffffff);
    for (int a = 1; a < 5; a++) bus(1, 8'(a * 4), 0);
    cnt = 0;
    repeat (20)
    begin
      x = rnd();
      b = x[0] | (cnt == 0);
      cmd_pulse <= 1;
      cmd_dir_neg <= b;
      cnt += b ? -1 : 1;
      @(posedge pclk);
    end
    cmd_pulse <= 0;
    @(posedge pclk);
    for (int a = 1; a < 5; a++)
    begin
      bus(0, 8'(a * 4), 0);
      chk("cnt", rd, 32'(cnt));
    end
    bus(1, 8'h30, 32'h100);
    bus(1, 8'h2c, rnd());
    bus(0, 8'h2c, 0);
    chk("latch", rd, 32'(cnt));
    bus(1, 8'h30, 32'h19);
    for (int a = 2; a < 5; a++) bus(1, 8'(a * 4), 0);
    ecnt = 0;
    enc_run <= 1;
    repeat (40) @(posedge pclk);
    enc_run <= 0;
    repeat (8) @(posedge pclk);
    for (int a = 2; a < 5; a++)
    begin
      bus(0, 8'(a * 4), 0);
      chk("enc", rd, 32'(ecnt));
    end
    bus(1, 8'h28, 32'hf5);
    for (int i = 0; i < 7; i++)
    begin
      p = i > 3 ? 6 - i : 7 - i;
      mev <= 7'(1 << i);
      @(posedge pclk);
      mev <= '0;
      @(posedge pclk);
      chk("cause", 32'(event_cause), 32'(8'hf5 & (8'h1 << p)));
    end
    bus(1, 8'h28, 32'h7ffff);
    for (int j = 6; j >= 0; j--)
    begin
      if (j == 5)
        continue;
      p = j == 6 ? 14 : j == 4 ? 13 : j == 3 ? 16 : j == 0 ? 18 : 17;
      pin_lvl[j] <= 1;
      for (int k = 0; k < 12 && event_irq !== 1'b1; k++) @(posedge pclk);
      chk("pin", 32'(event_cause), 32'h1 << p);
      @(posedge pclk);
    end
    final_report();
  end
endmodule
`default_nettype wire
